// ==== common/cwt_cfg.svh ====
// constants for the channel window threshold register group
`ifndef CWT_CFG_SVH
`define CWT_CFG_SVH

// register offsets on the serial register port
`define CWT_OFS_SCALING        8'h1F
`define CWT_OFS_FAST_UNDER     8'h20
`define CWT_OFS_FAST_OVER      8'h21
`define CWT_OFS_SLOW_UNDER     8'h22
`define CWT_OFS_SLOW_OVER      8'h23
`define CWT_OFS_DEBOUNCE       8'h24
`define CWT_OFS_CUTOFF         8'h25

// reset values
`define CWT_RST_SCALING        8'h00
`define CWT_RST_FAST_UNDER     8'h00
`define CWT_RST_FAST_OVER      8'hFF
`define CWT_RST_SLOW_UNDER     8'h00
`define CWT_RST_SLOW_OVER      8'hFF
`define CWT_RST_DEBOUNCE       8'h00
`define CWT_RST_CUTOFF         8'h04

// field positions
`define CWT_SCALING_MSB        5
`define CWT_SCALING_CH         0
`define CWT_OVER_DEB_MSB       7
`define CWT_OVER_DEB_LSB       4
`define CWT_UNDER_DEB_MSB      3
`define CWT_UNDER_DEB_LSB      0
`define CWT_CUTOFF_MSB         2
`define CWT_CUTOFF_LSB         0

// threshold code to millivolts
`define CWT_X1_BASE_MV         13'h00C8
`define CWT_X1_STEP_MV         13'h0005
`define CWT_X4_BASE_MV         13'h0320
`define CWT_X4_STEP_MV         13'h0014

// timing
`define CWT_CLK_MHZ            100
`define CWT_DEB_UNIT_NS        100
`define CWT_DEB_UNIT_CYCLES    ((`CWT_DEB_UNIT_NS * `CWT_CLK_MHZ + 999) / 1000)
`define CWT_DEB_MAX_CODE       4'hA
`define CWT_DEB_LONGEST_CYCLES (`CWT_DEB_UNIT_CYCLES << 10)
`define CWT_FILT_TICK_NS       10000
`define CWT_FILT_TICK_CYCLES   ((`CWT_FILT_TICK_NS * `CWT_CLK_MHZ) / 1000)

// cutoff codes
`define CWT_FC_250HZ           3'h2
`define CWT_FC_500HZ           3'h3
`define CWT_FC_1KHZ            3'h4
`define CWT_FC_2KHZ            3'h5
`define CWT_FC_4KHZ            3'h6

`endif

// ==== common/cwt_pkg.sv ====
// types shared by the channel window threshold block
package cwt_pkg;

    typedef logic [7:0]  cwt_byte_t;
    typedef logic [12:0] cwt_mv_t;
    typedef logic [13:0] cwt_count_t;
    typedef logic [3:0]  cwt_deb_code_t;
    typedef logic [2:0]  cwt_cutoff_t;

    // gray coded along idle -> counting -> fault
    typedef enum logic [1:0]
    {
        CWT_DEB_IDLE  = 2'b00,
        CWT_DEB_COUNT = 2'b01,
        CWT_DEB_FAULT = 2'b11
    } cwt_deb_state_e;

endpackage

// ==== logic/cwt_debounce.sv ====
// debouncer: asserts a fault once the comparator has held high for the target count
`timescale 1ns/1ps
`include "cwt_cfg.svh"

module cwt_debounce
    import cwt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // comparator and timing
    input  wire logic       cmp_raw,
    input  wire cwt_count_t target,
    // result
    output logic            fault
);

    cwt_deb_state_e state_reg;
    cwt_deb_state_e state_next;
    cwt_count_t     cnt_reg;
    cwt_count_t     cnt_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        // any drop of the comparator restarts the stability window
        unique case (state_reg)
            CWT_DEB_IDLE:
            begin
                cnt_next = 14'h0001;
                if (cmp_raw)
                begin
                    state_next = (target <= 14'h0001) ? CWT_DEB_FAULT : CWT_DEB_COUNT;
                end
            end
            CWT_DEB_COUNT:
            begin
                cnt_next = cnt_reg + 14'h0001;
                if (!cmp_raw)
                begin
                    state_next = CWT_DEB_IDLE;
                end
                else if (cnt_next >= target)
                begin
                    state_next = CWT_DEB_FAULT;
                end
            end
            CWT_DEB_FAULT:
            begin
                if (!cmp_raw)
                begin
                    state_next = CWT_DEB_IDLE;
                end
            end
            default:
            begin
                state_next = CWT_DEB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= CWT_DEB_IDLE;
            cnt_reg   <= 14'h0000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign fault = (state_reg == CWT_DEB_FAULT);

endmodule

// ==== logic/cwt_lowpass.sv ====
// first-order low-pass filter whose cutoff follows the cutoff code
`timescale 1ns/1ps
`include "cwt_cfg.svh"

module cwt_lowpass
    import cwt_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // sample stream
    input  wire logic        tick,
    input  wire cwt_mv_t     sample_mv,
    input  wire cwt_cutoff_t cutoff,
    // filtered value
    output cwt_mv_t          filt_mv
);

    // shift k gives alpha = 2^-k at the tick rate, about 2*pi*fc/fs
    function automatic logic [2:0] cutoff_shift(input cwt_cutoff_t code);
        logic [2:0] k;
        k = 3'h4;
        unique case (code)
            `CWT_FC_250HZ: k = 3'h6;
            `CWT_FC_500HZ: k = 3'h5;
            `CWT_FC_1KHZ:  k = 3'h4;
            `CWT_FC_2KHZ:  k = 3'h3;
            `CWT_FC_4KHZ:  k = 3'h2;
            default:       k = 3'h4;
        endcase
        return k;
    endfunction

    logic [20:0]        acc_reg;
    logic [20:0]        acc_next;
    logic               primed_reg;
    logic               primed_next;
    logic signed [21:0] diff;

    always_comb
    begin
        acc_next    = acc_reg;
        primed_next = primed_reg;
        diff        = $signed({1'b0, sample_mv, 8'h00}) - $signed({1'b0, acc_reg});
        if (tick)
        begin
            primed_next = 1'b1;
            // first sample loads straight in so the path leaves fault at the first tick instead of ramping up from zero
            if (!primed_reg)
            begin
                acc_next = {sample_mv, 8'h00};
            end
            else
            begin
                acc_next = 21'(acc_reg + 21'(diff >>> cutoff_shift(cutoff)));
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg    <= 21'h00_0000;
            primed_reg <= 1'b0;
        end
        else
        begin
            acc_reg    <= acc_next;
            primed_reg <= primed_next;
        end
    end

    assign filt_mv = acc_reg[20:8];

endmodule

// ==== logic/cwt_channel.sv ====
// channel 1 window threshold registers, comparators, debounce and slow-path filter
//
// Notes on behaviour
// - fast-path over limit: 8-bit read/write, resets to 0xFF.
// - scaling 1x: limit = 0.2 V + code * 5 mV.
// - scaling 4x: limit = 0.8 V + code * 20 mV.
// - slow-path under limit: 8-bit read/write, resets to 0x00.
// - slow-path over limit: 8-bit read/write, resets to 0xFF.
// - fast-path fault only after comparator stays set for whole debounce time.
// - debounce register: over code bits 7:4, under code 3:0, reset zero.
// - debounce code: 0.1 us doubling per step; codes 10 and up give 102.4 us.
// - debounce register resets to zero, selecting shortest times.
// - cutoff bits 2:0 pick 250 Hz to 4 kHz, reset 1 kHz, others invalid.
// - writing the cutoff retunes the low-pass filter of the slow path.
// - scaling bit clear picks 1x, set picks 4x, for all channel limits.
// - fast-path under limit: separate register one below over, resets zero.
`timescale 1ns/1ps
`include "cwt_cfg.svh"

module cwt_channel
    import cwt_pkg::*;
#(
    parameter int unsigned DEB_LONGEST_CYCLES = `CWT_DEB_LONGEST_CYCLES
)
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // register port
    input  wire cwt_byte_t reg_addr,
    input  wire logic      reg_wr,
    input  wire cwt_byte_t reg_wdata,
    input  wire logic      reg_rd,
    output cwt_byte_t      reg_rdata,
    output logic           reg_rd_valid,
    // monitored value in millivolts, from the measuring front end on clk
    input  wire cwt_mv_t   fast_mv,
    input  wire cwt_mv_t   slow_mv,
    // faults
    output logic           fast_over_fault,
    output logic           fast_under_fault,
    output logic           slow_over_fault,
    output logic           slow_under_fault,
    output logic           cutoff_invalid
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic cwt_mv_t code_to_mv(input cwt_byte_t code, input logic x4);
        cwt_mv_t mv;
        if (x4)
        begin
            mv = 13'(`CWT_X4_BASE_MV + 13'(code) * `CWT_X4_STEP_MV);
        end
        else
        begin
            mv = 13'(`CWT_X1_BASE_MV + 13'(code) * `CWT_X1_STEP_MV);
        end
        return mv;
    endfunction

    // codes past the longest step all share it; software is expected to stay at 0.4 us or above
    function automatic cwt_count_t deb_cycles(input cwt_deb_code_t code);
        cwt_deb_code_t c;
        cwt_count_t    n;
        c = (code > `CWT_DEB_MAX_CODE) ? `CWT_DEB_MAX_CODE : code;
        n = 14'(DEB_LONGEST_CYCLES >> (4'(`CWT_DEB_MAX_CODE) - c));
        return (n == 14'h0000) ? 14'h0001 : n;
    endfunction

    function automatic logic cutoff_is_valid(input cwt_cutoff_t code);
        return (code >= `CWT_FC_250HZ) && (code <= `CWT_FC_4KHZ);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file

    cwt_byte_t scaling_reg;
    cwt_byte_t scaling_next;
    cwt_byte_t fast_under_reg;
    cwt_byte_t fast_under_next;
    cwt_byte_t fast_over_reg;
    cwt_byte_t fast_over_next;
    cwt_byte_t slow_under_reg;
    cwt_byte_t slow_under_next;
    cwt_byte_t slow_over_reg;
    cwt_byte_t slow_over_next;
    cwt_byte_t debounce_reg;
    cwt_byte_t debounce_next;
    cwt_byte_t cutoff_reg;
    cwt_byte_t cutoff_next;
    cwt_byte_t rdata_reg;
    cwt_byte_t rdata_next;
    logic      rvalid_reg;
    logic      rvalid_next;

    always_comb
    begin
        scaling_next    = scaling_reg;
        fast_under_next = fast_under_reg;
        fast_over_next  = fast_over_reg;
        slow_under_next = slow_under_reg;
        slow_over_next  = slow_over_reg;
        debounce_next   = debounce_reg;
        cutoff_next     = cutoff_reg;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `CWT_OFS_SCALING:
                begin
                    scaling_next = {2'b00, reg_wdata[`CWT_SCALING_MSB:0]};
                end
                `CWT_OFS_FAST_UNDER:
                begin
                    fast_under_next = reg_wdata;
                end
                `CWT_OFS_FAST_OVER:
                begin
                    fast_over_next = reg_wdata;
                end
                `CWT_OFS_SLOW_UNDER:
                begin
                    slow_under_next = reg_wdata;
                end
                `CWT_OFS_SLOW_OVER:
                begin
                    slow_over_next = reg_wdata;
                end
                `CWT_OFS_DEBOUNCE:
                begin
                    debounce_next = reg_wdata;
                end
                `CWT_OFS_CUTOFF:
                begin
                    cutoff_next = reg_wdata;
                end
                default:
                begin
                    // writes elsewhere are ignored
                    scaling_next = scaling_reg;
                end
            endcase
        end
    end

    // read data reflects the state before a write in the same cycle
    always_comb
    begin
        rvalid_next = reg_rd;
        rdata_next  = rdata_reg;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `CWT_OFS_SCALING:    rdata_next = scaling_reg;
                `CWT_OFS_FAST_UNDER: rdata_next = fast_under_reg;
                `CWT_OFS_FAST_OVER:  rdata_next = fast_over_reg;
                `CWT_OFS_SLOW_UNDER: rdata_next = slow_under_reg;
                `CWT_OFS_SLOW_OVER:  rdata_next = slow_over_reg;
                `CWT_OFS_DEBOUNCE:   rdata_next = debounce_reg;
                `CWT_OFS_CUTOFF:     rdata_next = cutoff_reg;
                default:             rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scaling_reg    <= `CWT_RST_SCALING;
            fast_under_reg <= `CWT_RST_FAST_UNDER;
            fast_over_reg  <= `CWT_RST_FAST_OVER;
            slow_under_reg <= `CWT_RST_SLOW_UNDER;
            slow_over_reg  <= `CWT_RST_SLOW_OVER;
            debounce_reg   <= `CWT_RST_DEBOUNCE;
            cutoff_reg     <= `CWT_RST_CUTOFF;
            rdata_reg      <= 8'h00;
            rvalid_reg     <= 1'b0;
        end
        else
        begin
            scaling_reg    <= scaling_next;
            fast_under_reg <= fast_under_next;
            fast_over_reg  <= fast_over_next;
            slow_under_reg <= slow_under_next;
            slow_over_reg  <= slow_over_next;
            debounce_reg   <= debounce_next;
            cutoff_reg     <= cutoff_next;
            rdata_reg      <= rdata_next;
            rvalid_reg     <= rvalid_next;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign reg_rd_valid = rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // limits in millivolts and comparators

    logic          x4;
    cwt_count_t    over_target;
    cwt_count_t    under_target;
    cwt_cutoff_t   cutoff_code;
    logic          fast_over_cmp_reg;
    logic          fast_over_cmp_next;
    logic          fast_under_cmp_reg;
    logic          fast_under_cmp_next;
    logic          slow_over_cmp_reg;
    logic          slow_over_cmp_next;
    logic          slow_under_cmp_reg;
    logic          slow_under_cmp_next;
    cwt_mv_t       slow_filt_mv;

    assign x4           = scaling_reg[`CWT_SCALING_CH];
    assign over_target  = deb_cycles(debounce_reg[`CWT_OVER_DEB_MSB:`CWT_OVER_DEB_LSB]);
    assign under_target = deb_cycles(debounce_reg[`CWT_UNDER_DEB_MSB:`CWT_UNDER_DEB_LSB]);
    assign cutoff_code  = cutoff_reg[`CWT_CUTOFF_MSB:`CWT_CUTOFF_LSB];

    // each path is compared against its own pair of limits
    always_comb
    begin
        fast_over_cmp_next  = fast_mv > code_to_mv(fast_over_reg, x4);
        fast_under_cmp_next = fast_mv < code_to_mv(fast_under_reg, x4);
        slow_over_cmp_next  = slow_filt_mv > code_to_mv(slow_over_reg, x4);
        slow_under_cmp_next = slow_filt_mv < code_to_mv(slow_under_reg, x4);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fast_over_cmp_reg  <= 1'b0;
            fast_under_cmp_reg <= 1'b0;
            slow_over_cmp_reg  <= 1'b0;
            slow_under_cmp_reg <= 1'b0;
        end
        else
        begin
            fast_over_cmp_reg  <= fast_over_cmp_next;
            fast_under_cmp_reg <= fast_under_cmp_next;
            slow_over_cmp_reg  <= slow_over_cmp_next;
            slow_under_cmp_reg <= slow_under_cmp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fast-path debounce

    cwt_debounce u_over_deb
    (
        .clk     (clk),
        .rst     (rst),
        .cmp_raw (fast_over_cmp_reg),
        .target  (over_target),
        .fault   (fast_over_fault)
    );

    cwt_debounce u_under_deb
    (
        .clk     (clk),
        .rst     (rst),
        .cmp_raw (fast_under_cmp_reg),
        .target  (under_target),
        .fault   (fast_under_fault)
    );

    ////////////////////////////////////////////////////////////////////////////
    // slow path: sample tick divider and low-pass filter

    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic        tick;

    always_comb
    begin
        tick          = (tick_cnt_reg == 16'(`CWT_FILT_TICK_CYCLES - 1));
        tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_reg <= 16'h0000;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // invalid cutoff codes keep the filter at the 1 kHz setting
    cwt_lowpass u_lowpass
    (
        .clk       (clk),
        .rst       (rst),
        .tick      (tick),
        .sample_mv (slow_mv),
        .cutoff    (cutoff_code),
        .filt_mv   (slow_filt_mv)
    );

    assign slow_over_fault  = slow_over_cmp_reg;
    assign slow_under_fault = slow_under_cmp_reg;
    assign cutoff_invalid   = !cutoff_is_valid(cutoff_code);

endmodule

// ==== tb/cwt_channel_props.sv ====
// concurrent checks on the ports of the channel window threshold block
`timescale 1ns/1ps

module cwt_channel_props
    import cwt_pkg::*;
#(
    parameter int unsigned DEB_LONGEST_CYCLES = 10240
)
(
    // clock and reset
    input wire logic      clk,
    input wire logic      rst,
    // register port
    input wire cwt_byte_t reg_addr,
    input wire logic      reg_wr,
    input wire cwt_byte_t reg_wdata,
    input wire logic      reg_rd,
    input wire cwt_byte_t reg_rdata,
    input wire logic      reg_rd_valid,
    // monitored values
    input wire cwt_mv_t   fast_mv,
    input wire cwt_mv_t   slow_mv,
    // faults
    input wire logic      fast_over_fault,
    input wire logic      fast_under_fault,
    input wire logic      slow_over_fault,
    input wire logic      slow_under_fault,
    input wire logic      cutoff_invalid
);
    cwt_byte_t     scl_reg;
    cwt_byte_t     fun_reg;
    cwt_byte_t     fov_reg;
    cwt_byte_t     deb_reg;
    logic [13:0]   ovr_reg;
    logic [13:0]   unr_reg;
    cwt_deb_code_t ov_code;
    cwt_deb_code_t un_code;
    logic          ovc;
    logic          unc;

    function automatic cwt_mv_t lim(input logic s, input cwt_byte_t c);
        return s ? 13'h0320 + 13'h0014 * c : 13'h00C8 + 13'h0005 * c;
    endfunction

    function automatic int unsigned deb_n(input cwt_deb_code_t c);
        int unsigned n;
        n = DEB_LONGEST_CYCLES >> (4'hA - ((c > 4'hA) ? 4'hA : c));
        return (n == 0) ? 1 : n;
    endfunction

    assign ov_code = deb_reg[7:4];
    assign un_code = deb_reg[3:0];
    assign ovc = fast_mv > lim(scl_reg[0], fov_reg);
    assign unc = fast_mv < lim(scl_reg[0], fun_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the limits, so comparator timing can be judged from the ports alone
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_reg <= 8'h00;
            fun_reg <= 8'h00;
            fov_reg <= 8'hFF;
            deb_reg <= 8'h00;
            ovr_reg <= 14'h0000;
            unr_reg <= 14'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h1F) scl_reg <= reg_wdata;
            if (reg_wr && reg_addr == 8'h20) fun_reg <= reg_wdata;
            if (reg_wr && reg_addr == 8'h21) fov_reg <= reg_wdata;
            if (reg_wr && reg_addr == 8'h24) deb_reg <= reg_wdata;
            // saturating run lengths; the longest debounce fits well below the top
            ovr_reg <= ovc ? ovr_reg + 14'(ovr_reg != 14'h3FFF) : 14'h0000;
            unr_reg <= unc ? unr_reg + 14'(unr_reg != 14'h3FFF) : 14'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_take;
        reg_rd;
    endsequence

    sequence rd_reply;
        reg_rd_valid;
    endsequence

    rd_answer_a: assert property (rd_take |=> rd_reply) else $error("read without answer");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rd_valid && $stable(reg_rdata))
        else $error("read answer without strobe");
    over_read_a: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata == $past(fov_reg))
        else $error("fast over limit read wrong");
    cutoff_flag_a: assert property (reg_wr && reg_addr == 8'h25
        |=> cutoff_invalid == ($past(reg_wdata[2:0]) inside {3'h0, 3'h1, 3'h7})) else $error("cutoff flag wrong");
    over_rise_a: assert property ($rose(fast_over_fault) |-> $past(ovr_reg) >= deb_n($past(ov_code)))
        else $error("over fault rose early");
    over_hold_a: assert property (ovr_reg > deb_n(ov_code) |-> fast_over_fault)
        else $error("over fault late");
    over_drop_a: assert property (!ovc |-> ##2 !fast_over_fault)
        else $error("over fault kept");
    under_rise_a: assert property ($rose(fast_under_fault) |-> $past(unr_reg) >= deb_n($past(un_code)))
        else $error("under fault rose early");
    under_hold_a: assert property (unr_reg > deb_n(un_code) |-> fast_under_fault)
        else $error("under fault late");
    under_drop_a: assert property (!unc |-> ##2 !fast_under_fault)
        else $error("under fault kept");
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the channel window threshold block
`timescale 1ns/1ps

module tb
    import cwt_pkg::*;
;

    localparam int unsigned DEB = 1024;

    logic      clk;
    logic      rst;
    cwt_byte_t reg_addr;
    logic      reg_wr;
    cwt_byte_t reg_wdata;
    logic      reg_rd;
    cwt_byte_t reg_rdata;
    logic      reg_rd_valid;
    cwt_mv_t   fast_mv;
    cwt_mv_t   slow_mv;
    logic      fast_over_fault;
    logic      fast_under_fault;
    logic      slow_over_fault;
    logic      slow_under_fault;
    logic      cutoff_invalid;
    cwt_byte_t q;
    cwt_byte_t a;
    cwt_byte_t d;
    cwt_byte_t exp_mem [0:255];
    cwt_mv_t   lv;
    cwt_mv_t   mv;
    logic      s;
    int        miscompares;
    int        checks;
    int        n;

    cwt_channel #(.DEB_LONGEST_CYCLES(DEB)) u_cwt_channel (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .fast_mv(fast_mv),
        .slow_mv(slow_mv), .fast_over_fault(fast_over_fault), .fast_under_fault(fast_under_fault),
        .slow_over_fault(slow_over_fault), .slow_under_fault(slow_under_fault), .cutoff_invalid(cutoff_invalid)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic cwt_byte_t rst_val(input cwt_byte_t ad);
        case (ad)
            8'h21, 8'h23: return 8'hFF;
            8'h25: return 8'h04;
            default: return 8'h00;
        endcase
    endfunction

    function automatic cwt_mv_t lim_mv(input logic sc, input cwt_byte_t c);
        return sc ? 13'h0320 + 13'h0014 * c : 13'h00C8 + 13'h0005 * c;
    endfunction

    function automatic int deb_edges(input int c);
        int k;
        k = DEB >> (10 - ((c > 10) ? 10 : c));
        return ((k == 0) ? 1 : k) + 1;
    endfunction

    // ticks for the filter to fall from 2048 mV below the default over limit
    function automatic int fticks(input int c);
        int y;
        int k;
        int m;
        k = (c == 2) ? 6 : (c == 3) ? 5 : (c == 5) ? 3 : (c == 6) ? 2 : 4;
        y = 2048;
        m = 0;
        while (y > lim_mv(1'b0, 8'hFF))
        begin
            y = y - ((y + (1 << k) - 1) >> k);
            m++;
        end
        return m;
    endfunction

    function automatic logic cur(input int sel);
        return (sel == 0) ? fast_over_fault : (sel == 1) ? fast_under_fault : slow_over_fault;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        checks++;
        if (got !== want)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic upd(input cwt_byte_t ad, input cwt_byte_t dv);
        if (ad == 8'h1F)
            exp_mem[ad] = dv & 8'h3F;
        else if (ad >= 8'h20 && ad <= 8'h25)
            exp_mem[ad] = dv;
    endtask

    task automatic xfer(input cwt_byte_t ad, input logic w, input cwt_byte_t dv, input logic r);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dv;
        reg_wr <= w;
        reg_rd <= r;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic wr(input cwt_byte_t ad, input cwt_byte_t dv);
        xfer(ad, 1'b1, dv, 1'b0);
        upd(ad, dv);
    endtask

    // a write issued with the read must not show in that read
    task automatic rd_chk(input cwt_byte_t ad, input logic w, input cwt_byte_t dv);
        xfer(ad, w, dv, 1'b1);
        chk(reg_rd_valid, 1'b1);
        chk(q, exp_mem[ad]);
        if (w) upd(ad, dv);
    endtask

    task automatic wait_sel(input int sel, input logic want, input int lim);
        n = 0;
        while (cur(sel) !== want && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            chk(16'h0000, 16'h0001);
            end_of_test();
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 256; i++) exp_mem[i] = rst_val(8'(i));
    endtask

    task automatic end_of_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        fast_mv = 13'h00C8;
        slow_mv = 13'h0000;
        miscompares = 0;
        checks = 0;
        n = $urandom(32'hB982_CAD1);
        do_reset();
        for (int i = 8'h1E; i <= 8'h26; i++) rd_chk(8'(i), 1'b0, 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            a = 8'h1E + 8'($urandom % 9);
            if (a == 8'h24) a = 8'h26;
            d = 8'($urandom);
            if ($urandom % 2) rd_chk(a, 1'b1, d);
            else wr(a, d);
            rd_chk(a, 1'b0, 8'h00);
        end
        wr(8'h24, 8'h22);
        for (int i = 0; i < 24; i++)
        begin
            s = 1'($urandom);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            wr(8'h1F, {7'h00, s});
            wr(8'h20, d);
            wr(8'h21, d);
            lv = lim_mv(s, d);
            mv = lv - 13'h0002 + 13'($urandom % 5);
            @(posedge clk);
            fast_mv <= mv;
            repeat (8) @(posedge clk);
            #1;
            chk({fast_over_fault, fast_under_fault}, {mv > lv, mv < lv});
        end
        wr(8'h1F, 8'h00);
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h00);
        @(posedge clk);
        fast_mv <= 13'h00C8;
        // codes under 2 lie below the supported debounce range, so they are never set
        for (int c = 2; c < 16; c++)
        begin
            rd_chk(8'h24, 1'b1, {4'(c), 4'(17 - c)});
            rd_chk(8'h24, 1'b0, 8'h00);
            for (int side = 0; side < 2; side++)
            begin
                @(posedge clk);
                fast_mv <= side ? 13'h0064 : 13'h012C;
                wait_sel(side, 1'b1, 2100);
                chk(16'(n), 16'(deb_edges(side ? 17 - c : c)));
                @(posedge clk);
                fast_mv <= 13'h00C8;
                repeat (2) @(posedge clk);
                #1;
                chk({fast_over_fault, fast_under_fault}, 2'b00);
            end
        end
        for (int c = 0; c < 8; c++)
        begin
            if (c >= 2)
            begin
                @(posedge clk);
                do_reset();
                slow_mv <= 13'h0800;
            end
            wr(8'h25, 8'(c));
            chk(cutoff_invalid, c == 0 || c == 1 || c == 7);
            if (c >= 2)
            begin
                wait_sel(2, 1'b1, 1100);
                chk(slow_under_fault, 1'b0);
                @(posedge clk);
                slow_mv <= 13'h0000;
                wait_sel(2, 1'b0, 30000);
                chk(n > (fticks(c) - 2) * 1000 && n <= (fticks(c) + 1) * 1000 + 3, 1'b1);
            end
        end
        end_of_test();
    end
endmodule

bind cwt_channel cwt_channel_props #(.DEB_LONGEST_CYCLES(DEB_LONGEST_CYCLES)) u_cwt_channel_props (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .fast_mv(fast_mv),
    .slow_mv(slow_mv), .fast_over_fault(fast_over_fault), .fast_under_fault(fast_under_fault),
    .slow_over_fault(slow_over_fault), .slow_under_fault(slow_under_fault), .cutoff_invalid(cutoff_invalid)
);
